/* File: testbench/alu_status_register_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module alu_status_register_asserts
   import flags_pkg::*;
(
   input  wire logic                 ref_clk_i,
   input  wire logic                 rstn_i,
   input  wire logic                 instr_wr_i,
   input  wire logic [7:0]           instr_wdata_i,
   input  wire flags_pkg::alu_kind_t alu_kind_i,
   input  wire logic [7:0]           alu_a_i,
   input  wire logic [7:0]           alu_b_i,
   input  wire logic                 watchdog_clear_instr_i,
   input  wire logic                 sleep_instr_i,
   input  wire logic                 watchdog_timeout_i,
   input  wire logic [7:0]           processor_flags_o,
   input  wire logic [1:0]           direct_bank_o,
   input  wire logic                 upper_half_sel_o
);
   // ************************************************************
   // reference arithmetic, gated until the two-flop release is over
   // ************************************************************
   logic            [1:0] up_q;
   logic            [1:0] up_d;
   wire  logic            ev = watchdog_clear_instr_i | sleep_instr_i | watchdog_timeout_i;
   wire  logic            sb = alu_kind_i == ALU_SUB;
   wire  logic      [7:0] bb = sb ? ~alu_b_i : alu_b_i;
   wire  logic      [8:0] s  = {1'b0, alu_a_i} + {1'b0, bb} + {8'h00, sb};
   wire  logic      [4:0] h  = {1'b0, alu_a_i[3:0]} + {1'b0, bb[3:0]} + {4'h0, sb};
   wire  logic      [7:0] f  = processor_flags_o;
   always_comb up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         up_q <= 2'h0;
      end else begin
         up_q <= up_d;
      end
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i || up_q != 2'h3);
   // ************************************************************
   // properties
   // ************************************************************
   chk_bank_decode: assert property (
      direct_bank_o == f[6:5] && upper_half_sel_o == f[7]) else $error("bank decode mismatch");
   chk_add_flags: assert property (alu_kind_i == ALU_ADD |=>
      f[2:0] == {$past(s[7:0]) == 8'h00, $past(h[4]), $past(s[8])}) else $error("add flags wrong");
   chk_sub_borrow: assert property (alu_kind_i == ALU_SUB |=>
      f[2:0] == {$past(s[7:0]) == 8'h00, $past(h[4]), $past(s[8])}) else $error("sub flags wrong");
   chk_hw_only: assert property (instr_wr_i && !ev |=>
      $stable(f[4:3])) else $error("hardware flag written");
   chk_clear_file: assert property (
      instr_wr_i && instr_wdata_i == 8'h00 && alu_kind_i == ALU_LOGIC && alu_b_i == 8'h00 && !ev |=>
      f[7:5] == 3'h0 && f[2] && $stable(f[4:3]) && $stable(f[1:0])) else $error("clear pattern wrong");
   chk_logic_lock: assert property (instr_wr_i && alu_kind_i == ALU_LOGIC && !ev |=>
      $stable(f[1:0]) && f[2] == ($past(alu_b_i) == 8'h00)) else $error("logic op flags wrong");
   chk_move_keep: assert property (instr_wr_i && alu_kind_i == ALU_NONE && !ev |=>
      f == {$past(instr_wdata_i[7:5]), $past(f[4:3]), $past(instr_wdata_i[2:0])}) else $error("move wrong");
   chk_timeout_clr: assert property (watchdog_timeout_i |=>
      !f[4]) else $error("timeout flag not cleared");
   chk_sleep_powerdown: assert property (sleep_instr_i && !watchdog_timeout_i |=>
      f[4:3] == 2'b10) else $error("sleep flags wrong");
endmodule
bind alu_status_register alu_status_register_asserts chk_u (.*);
`default_nettype wire

/* File: testbench/alu_status_register_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module alu_status_register_tb;
   import flags_pkg::*;
   logic        ref_clk_i = 1'b0, rstn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic        instr_wr_i = 1'b0, watchdog_clear_instr_i = 1'b0, sleep_instr_i = 1'b0;
   logic        watchdog_timeout_i = 1'b0, upper_half_sel_o, pready_o, pslverr_o, er;
   logic [13:0] paddr_i = 14'h0000;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
   logic [7:0]  instr_wdata_i = 8'h00, alu_a_i = 8'h00, alu_b_i = 8'h00, processor_flags_o;
   logic [1:0]  direct_bank_o;
   alu_kind_t   alu_kind_i = ALU_NONE;
   int          miscompares = 0, tests_run = 0;
   alu_status_register dut_u (.*, .pstrb_i(4'hF));
   always #2 ref_clk_i = ~ref_clk_i;
   task automatic report_and_stop();
      if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // request held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      psel_i    <= 1'b1;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= d;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      do @(posedge ref_clk_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      er = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask
   // one core cycle; events suppress the instruction write
   task automatic core(input logic [7:0] d, input alu_kind_t k, input logic [7:0] a, b, input logic [2:0] ev,
                       input logic [7:0] e);
      @(posedge ref_clk_i);
      instr_wr_i    <= ev == 3'h0;
      instr_wdata_i <= d;
      alu_kind_i    <= k;
      alu_a_i       <= a;
      alu_b_i       <= b;
      {watchdog_clear_instr_i, sleep_instr_i, watchdog_timeout_i} <= ev;
      @(posedge ref_clk_i);
      instr_wr_i    <= 1'b0;
      alu_kind_i    <= ALU_NONE;
      {watchdog_clear_instr_i, sleep_instr_i, watchdog_timeout_i} <= 3'h0;
      #1;
      chk("flags", {24'h0, e}, {24'h0, processor_flags_o});
   endtask
   initial begin
      #20000;
      miscompares++;
      report_and_stop();
   end
   initial begin
      repeat (12) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      apb(1'b0, FLAGS_ADDR, 32'h0);
      chk("reset", 32'h0000_0018, rd);
      apb(1'b1, FLAGS_ADDR, 32'h0000_0000);
      apb(1'b0, FLAGS_ADDR, 32'h0);
      chk("wr_zero", 32'h0000_0018, rd);
      apb(1'b1, FLAGS_ADDR, 32'h0000_00A5);
      apb(1'b0, FLAGS_ADDR, 32'h0);
      chk("wr_a5", 32'h0000_00BD, rd);
      apb(1'b0, FLAGS_ADDR + 14'h0004, 32'h0);
      chk("unmapped", 32'h0000_0001, {rd[30:0], er});
      for (int i = 0; i < 8; i++) begin
         core({i[2:0], 5'h07}, ALU_NONE, 8'h00, 8'h00, 3'h0, {i[2:0], 5'h1F});
         chk("bank", {29'h0, i[2:0]}, {29'h0, upper_half_sel_o, direct_bank_o});
      end
      // a logic op with a non-zero result keeps both carries and clears zero
      core(8'h00, ALU_LOGIC, 8'h00, 8'h5A, 3'h0, 8'h1B);
      core(8'h00, ALU_LOGIC, 8'h00, 8'h00, 3'h0, 8'h1F);
      core(8'hF8, ALU_ADD, 8'h8F, 8'h71, 3'h0, 8'hFF);
      core(8'h07, ALU_SUB, 8'h10, 8'h20, 3'h0, 8'h1A);
      core(8'h00, ALU_NONE, 8'h00, 8'h00, 3'b010, 8'h12);
      core(8'h00, ALU_NONE, 8'h00, 8'h00, 3'b001, 8'h02);
      core(8'h00, ALU_NONE, 8'h00, 8'h00, 3'b100, 8'h1A);
      apb(1'b0, FLAGS_ADDR, 32'h0);
      chk("final", 32'h0000_001A, rd);
      report_and_stop();
   end
endmodule
`default_nettype wire

/* File: verilog/alu_status_register.sv */
`timescale 1ns/1ps
`default_nettype none
module alu_status_register
   import flags_pkg::*;
(
   input  wire logic                 ref_clk_i,
   input  wire logic                 rstn_i,
   // apb slave
   input  wire logic                 psel_i,
   input  wire logic                 penable_i,
   input  wire logic                 pwrite_i,
   input  wire logic [13:0]          paddr_i,
   input  wire logic [31:0]          pwdata_i,
   input  wire logic [3:0]           pstrb_i,
   output logic      [31:0]          prdata_o,
   output logic                      pready_o,
   output logic                      pslverr_o,
   // instruction destination write
   input  wire logic                 instr_wr_i,
   input  wire logic [7:0]           instr_wdata_i,
   // flag logic operation of the same instruction
   input  wire flags_pkg::alu_kind_t alu_kind_i,
   input  wire logic [7:0]           alu_a_i,
   input  wire logic [7:0]           alu_b_i,
   // reset-cause events, one-cycle pulses
   input  wire logic                 watchdog_clear_instr_i,
   input  wire logic                 sleep_instr_i,
   input  wire logic                 watchdog_timeout_i,
   // register contents and decoded bank selects
   output logic      [7:0]           processor_flags_o,
   output logic      [1:0]           direct_bank_o,
   output logic                      upper_half_sel_o
);
   import flags_pkg::*;

   // ************************************************************
   // reset release
   // ************************************************************
   // a raw release could reach the flops in different cycles; two stages make it one edge for all
   logic rst_meta_q;
   logic rst_meta_d;
   logic rst_n_q;
   logic rst_n_d;

   always_comb begin
      rst_meta_d = 1'b1;
      rst_n_d    = rst_meta_q;
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= rst_meta_d;
         rst_n_q    <= rst_n_d;
      end
   end

   // ************************************************************
   // flag logic
   // ************************************************************
   logic [7:0] alu_res;
   logic [7:0] alu_mask;
   logic       alu_digit_carry;
   logic       alu_carry_out;
   logic       carry_in;
   logic [4:0] low_sum;
   logic [8:0] full_sum;
   logic [7:0] addend;

   // the adder runs every cycle; alu_mask alone decides which flags it may touch
   always_comb begin
      carry_in        = (alu_kind_i == ALU_SUB);
      // subtraction adds the two's complement, so carry out means no borrow
      addend          = carry_in ? ~alu_b_i : alu_b_i;
      low_sum         = {1'b0, alu_a_i[3:0]} + {1'b0, addend[3:0]} + {4'h0, carry_in};
      full_sum        = {1'b0, alu_a_i} + {1'b0, addend} + {8'h00, carry_in};
      alu_digit_carry = low_sum[4];
      alu_carry_out   = full_sum[8];
      alu_res         = full_sum[7:0];

      case (alu_kind_i)
         ALU_ADD,
         ALU_SUB: begin
            alu_mask = ARITH_MASK;
         end
         // logic ops report zero on the operand path b
         ALU_LOGIC: begin
            alu_mask = ZERO_MASK;
            alu_res  = alu_b_i;
         end
         default: begin
            alu_mask = 8'h00;
         end
      endcase
   end

   // ************************************************************
   // apb access
   // ************************************************************
   // the single register sits at the byte address four times its index
   logic        hit;
   logic        access;
   logic        ack;
   logic        pready_q;
   logic        pready_d;
   logic        pslverr_q;
   logic        pslverr_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic        apb_wr;

   always_comb begin
      hit       = (paddr_i == FLAGS_ADDR);
      access    = psel_i && penable_i;
      // one wait state so that read data can come from a flop
      ack       = access && !pready_q;
      pready_d  = ack;
      pslverr_d = ack && !hit;
      prdata_d  = 32'h0000_0000;
      // a read sees the register as it stood in the wait state
      if (ack && hit && !pwrite_i) begin
         prdata_d = {24'h000000, processor_flags_o};
      end
      // the write lands on the edge at which the master sees ready; only the low lane exists
      apb_wr    = access && pready_q && pwrite_i && hit && pstrb_i[0];
   end

   // ready, error and read data each stand for one cycle only
   always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q  <= prdata_d;
      end
   end

   assign pready_o  = pready_q;
   assign pslverr_o = pslverr_q;
   assign prdata_o  = prdata_q;

   // ************************************************************
   // flags register
   // ************************************************************
   logic [7:0] flags_q;
   logic [7:0] flags_d;
   logic [7:0] lock_mask;
   logic [7:0] wr_mask;
   logic [7:0] merged;
   logic       timeout_d;
   logic       powerdown_d;

   always_comb begin
      // any op that touches an arithmetic flag locks all three against the write data
      lock_mask = HW_ONLY_MASK;
      if (alu_mask != 8'h00) begin
         lock_mask = HW_ONLY_MASK | ARITH_MASK;
      end
      wr_mask = 8'h00;
      if (instr_wr_i) begin
         wr_mask = ~lock_mask;
      end
      // software write is applied first; the core's instruction write wins bitwise
      merged = flags_q;
      if (apb_wr) begin
         merged = (flags_q & HW_ONLY_MASK) | (pwdata_i[7:0] & ~HW_ONLY_MASK);
      end
      merged = (merged & ~wr_mask) | (instr_wdata_i & wr_mask);
      // flag logic overrides both writers on the bits that the op owns
      if (alu_mask[BIT_ZERO]) begin
         merged[BIT_ZERO] = (alu_res == 8'h00);
      end
      if (alu_mask[BIT_CARRY]) begin
         merged[BIT_DIGIT_CARRY] = alu_digit_carry;
         merged[BIT_CARRY]       = alu_carry_out;
      end

      // reset-cause flags move only on their own events
      timeout_d   = flags_q[BIT_TIMEOUT];
      powerdown_d = flags_q[BIT_POWERDOWN];
      if (watchdog_clear_instr_i || sleep_instr_i) begin
         timeout_d = 1'b1;
      end
      // a same-cycle time-out wins, so the watchdog event is never lost
      if (watchdog_timeout_i) begin
         timeout_d = 1'b0;
      end
      if (watchdog_clear_instr_i) begin
         powerdown_d = 1'b1;
      end
      // entering sleep must leave its mark even if a clear collides with it
      if (sleep_instr_i) begin
         powerdown_d = 1'b0;
      end
      flags_d                = merged;
      flags_d[BIT_TIMEOUT]   = timeout_d;
      flags_d[BIT_POWERDOWN] = powerdown_d;
   end

   // arithmetic flags come out of reset as zero: a defined start costs nothing
   always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         flags_q <= FLAGS_RESET;
      end else begin
         flags_q <= flags_d;
      end
   end

   // ************************************************************
   // outputs, all taken straight from the register
   // ************************************************************
   // the bank selects feed address decode directly, so they are not registered again
   assign processor_flags_o = flags_q;
   assign direct_bank_o     = flags_q[BIT_BANK_HI:BIT_BANK_LO];
   assign upper_half_sel_o  = flags_q[BIT_IND_BANK];

endmodule
`default_nettype wire

/* File: verilog/flags_pkg.sv */
// Summary of operation
// - instruction writes may target the flags register like any file register
// - bits updated by the flag logic ignore instruction write data
// - time-out and power-down flags ignore every write
// - clear-file on the register zeroes bank selects, sets zero, keeps the rest
// - bit clear, bit set, swap and move writes load arithmetic flags from the write data
// - in subtraction carry and digit carry mean no borrow
// - direct bank select pair picks bank 0 to 3, 00 to 11
// - indirect bank select set picks banks 2 and 3, clear picks 0 and 1
// - time-out set at power-up, watchdog clear, sleep; cleared by watchdog time-out
// - digit carry from bit 3 carry-out, carry from bit 7 carry-out
`default_nettype none
package flags_pkg;

   // ************************************************************
   // register map and field positions
   // ************************************************************
   localparam logic [11:0] FLAGS_INDEX     = 12'h183;
   localparam logic [13:0] FLAGS_ADDR      = {FLAGS_INDEX, 2'b00};
   localparam int          BIT_IND_BANK    = 7;
   localparam int          BIT_BANK_HI     = 6;
   localparam int          BIT_BANK_LO     = 5;
   localparam int          BIT_TIMEOUT     = 4;
   localparam int          BIT_POWERDOWN   = 3;
   localparam int          BIT_ZERO        = 2;
   localparam int          BIT_DIGIT_CARRY = 1;
   localparam int          BIT_CARRY       = 0;
   // arithmetic flags are undefined after power-on; hardware picks zero
   localparam logic [7:0]  FLAGS_RESET     = 8'h18;
   localparam logic [7:0]  HW_ONLY_MASK    = 8'h18;
   localparam logic [7:0]  ARITH_MASK      = 8'h07;
   localparam logic [7:0]  ZERO_MASK       = 8'h04;

   typedef enum logic [1:0] {
      ALU_NONE  = 2'b00,
      ALU_ADD   = 2'b01,
      ALU_SUB   = 2'b11,
      ALU_LOGIC = 2'b10
   } alu_kind_t;

endpackage
`default_nettype wire
